// ---- twm_ctrl.sv ----
// two-wire bus controller: master, bus monitor and slave
`timescale 1ns/1ps
module twm_ctrl (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       bus_data_pin_in,
	output logic            bus_data_pin_out,
	output logic            bus_data_pin_oe,
	input  wire logic       bus_clock_pin_in,
	output logic            bus_clock_pin_out,
	output logic            bus_clock_pin_oe,
	input  wire logic [7:0] bus_clock_prescale,
	input  wire logic       speed_fast,
	input  wire logic       internal_loop_select,
	input  wire logic [7:0] master_target_address_reg,
	input  wire logic [7:0] mst_tx_data,
	input  wire logic       mst_cmd_run,
	input  wire logic       mst_cmd_start,
	input  wire logic       mst_cmd_stop,
	input  wire logic       mst_cmd_ack,
	input  wire logic       mst_cmd_halt,
	output logic            mst_done,
	output logic            mst_error,
	output logic            mst_arb_lost,
	output logic            mst_busy,
	output logic [7:0]      mst_rx_data,
	output logic            bus_busy,
	input  wire logic [6:0] slv_own_addr,
	input  wire logic [7:0] slv_tx_data,
	input  wire logic       slv_tx_load,
	output logic [7:0]      slv_rx_data,
	output logic            slv_rx_req,
	output logic            slv_tx_req,
	output logic            slv_first_byte
);
	typedef struct packed {
		twm_pkg::twm_mst_t st;
		logic [8:0]        pre;
		logic [3:0]        ph;
		logic [7:0]        sh;
		logic [2:0]        bitn;
		logic              rx;
		logic              adr;
		logic              ackb;
		logic              stop_pend;
		logic              drv;
		logic              sda_oe;
		logic              scl_oe;
		logic              pin_sda_oe;
		logic              pin_scl_oe;
		logic              pin_out;
		logic              p_sda;
		logic              p_scl;
		logic              bus_busy;
		logic              done;
		logic              err;
		logic              lost;
		logic              busy;
		logic [7:0]        rdata;
	} twm_mst_state_t;

	twm_mst_state_t s;
	twm_mst_state_t next_s;
	logic           s_sda_oe;
	logic           s_scl_oe;
	logic           sda_line;
	logic           scl_line;
	logic           start_det;
	logic           stop_det;
	logic           lines_idle;

	// ==========================================
	// line levels
	// in loop mode the pads are released so the outside bus is untouched
	always_comb begin
		if (internal_loop_select) begin
			sda_line = ~(s.sda_oe | s_sda_oe);
			scl_line = ~(s.scl_oe | s_scl_oe);
		end else begin
			sda_line = bus_data_pin_in;
			scl_line = bus_clock_pin_in;
		end
		start_det = s.p_scl & scl_line & s.p_sda & ~sda_line;
		stop_det = s.p_scl & scl_line & ~s.p_sda & sda_line;
		lines_idle = sda_line & scl_line;
	end

	// ==========================================
	// slave function
	twm_slave u_slave (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.sda_line   (sda_line),
		.scl_line   (scl_line),
		.start_det  (start_det),
		.stop_det   (stop_det),
		.own_addr   (slv_own_addr),
		.tx_data    (slv_tx_data),
		.tx_load    (slv_tx_load),
		.sda_oe     (s_sda_oe),
		.scl_oe     (s_scl_oe),
		.rx_data    (slv_rx_data),
		.rx_req     (slv_rx_req),
		.tx_req     (slv_tx_req),
		.first_byte (slv_first_byte)
	);

	// ==========================================
	// unit length from the prescale setting
	function automatic logic [8:0] unit_reload(input logic [7:0] tpr,
		input logic fast);
		logic [7:0] t;
		t = tpr;
		if (tpr == twm_pkg::BYTE_RST) begin
			t = fast ? twm_pkg::PRESCALE_FAST : twm_pkg::PRESCALE_STD;
		end
		unit_reload = {t, 1'b1};
	endfunction

	// ==========================================
	// master next state
	logic       active;
	logic       stretch;
	logic       tick;
	logic [3:0] endv;
	logic       fin;
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.p_sda = sda_line;
		next_s.p_scl = scl_line;
		next_s.pin_out = 1'b0;
		if (start_det) begin
			next_s.bus_busy = 1'b1;
		end else if (stop_det) begin
			next_s.bus_busy = 1'b0;
		end
		active = s.st == twm_pkg::M_START || s.st == twm_pkg::M_DATA ||
			s.st == twm_pkg::M_ACK || s.st == twm_pkg::M_STOP;
		// a held clock freezes the unit timer; costs no slack
		stretch = active && !s.scl_oe && !scl_line;
		tick = 1'b0;
		if (active && !stretch) begin
			if (s.pre == twm_pkg::PRE_RST) begin
				next_s.pre = unit_reload(bus_clock_prescale, speed_fast);
				tick = 1'b1;
			end else begin
				next_s.pre = s.pre - 9'h001;
			end
		end
		endv = (s.st == twm_pkg::M_START || s.st == twm_pkg::M_STOP) ?
			twm_pkg::COND_END : twm_pkg::BIT_END;
		fin = tick && s.ph == endv - 4'h1;
		if (tick && !fin) begin
			next_s.ph = s.ph + 4'h1;
			if (s.ph == twm_pkg::CNT_RST) begin
				next_s.sda_oe = s.drv;
			end
			if (s.ph == twm_pkg::BIT_END - 4'h1) begin
				// second half of a condition, clock high
				next_s.sda_oe = s.st == twm_pkg::M_START;
			end
		end
		case (s.st)
		twm_pkg::M_IDLE: begin
			next_s.sda_oe = 1'b0;
			if (mst_cmd_run && mst_cmd_start) begin
				next_s.err = 1'b0;
				next_s.lost = 1'b0;
				if (s.bus_busy || !lines_idle) begin
					next_s.err = 1'b1;
					next_s.done = 1'b1;
				end else begin
					next_s.st = twm_pkg::M_START;
					next_s.ph = twm_pkg::LOW_UNITS;
					next_s.sh = master_target_address_reg;
					next_s.stop_pend = mst_cmd_stop;
					next_s.pre = unit_reload(bus_clock_prescale, speed_fast);
				end
			end
		end
		twm_pkg::M_START: begin
			if (fin) begin
				next_s.st = twm_pkg::M_DATA;
				next_s.ph = twm_pkg::CNT_RST;
				next_s.bitn = 3'h0;
				next_s.adr = 1'b1;
				next_s.rx = 1'b0;
				next_s.drv = ~s.sh[7];
			end
		end
		twm_pkg::M_DATA: begin
			if (fin) begin
				next_s.sh = {s.sh[6:0], sda_line};
				next_s.ph = twm_pkg::CNT_RST;
				next_s.bitn = s.bitn + 3'h1;
				next_s.drv = s.rx ? 1'b0 : ~s.sh[6];
				if (!s.rx && !s.sda_oe && !sda_line) begin
					next_s.st = twm_pkg::M_LOST;
					next_s.sda_oe = 1'b0;
					next_s.lost = 1'b1;
					next_s.err = 1'b1;
					next_s.done = 1'b1;
				end else if (s.bitn == 3'h7) begin
					next_s.st = twm_pkg::M_ACK;
					next_s.drv = s.rx & s.ackb;
				end
			end
		end
		twm_pkg::M_ACK: begin
			if (fin) begin
				next_s.ph = twm_pkg::CNT_RST;
				next_s.done = 1'b1;
				next_s.adr = 1'b0;
				next_s.st = twm_pkg::M_HOLD;
				if (s.rx) begin
					next_s.rdata = s.sh;
				end
				if (s.adr) begin
					next_s.rx = s.sh[0];
				end
				if (!s.rx && sda_line) begin
					next_s.err = 1'b1;
					next_s.st = twm_pkg::M_STOP;
					next_s.drv = 1'b1;
				end else if (s.stop_pend && !s.adr) begin
					next_s.st = twm_pkg::M_STOP;
					next_s.drv = 1'b1;
				end
			end
		end
		twm_pkg::M_HOLD: begin
			if (mst_cmd_run) begin
				next_s.err = 1'b0;
				next_s.stop_pend = mst_cmd_stop;
				next_s.pre = unit_reload(bus_clock_prescale, speed_fast);
				next_s.ph = twm_pkg::CNT_RST;
				if (mst_cmd_start) begin
					next_s.st = twm_pkg::M_START;
					next_s.sh = master_target_address_reg;
					next_s.drv = 1'b0;
				end else begin
					next_s.st = twm_pkg::M_DATA;
					next_s.bitn = 3'h0;
					next_s.ackb = mst_cmd_ack;
					next_s.sh = s.rx ? twm_pkg::BYTE_RST : mst_tx_data;
					next_s.drv = s.rx ? 1'b0 : ~mst_tx_data[7];
				end
			end else if (mst_cmd_halt) begin
				next_s.st = twm_pkg::M_STOP;
				next_s.ph = twm_pkg::CNT_RST;
				next_s.drv = 1'b1;
				next_s.pre = unit_reload(bus_clock_prescale, speed_fast);
			end
		end
		twm_pkg::M_STOP: begin
			if (fin) begin
				next_s.st = twm_pkg::M_IDLE;
				next_s.ph = twm_pkg::CNT_RST;
				next_s.sda_oe = 1'b0;
				next_s.done = 1'b1;
			end
		end
		twm_pkg::M_LOST: begin
			// retired: stays off the bus until it is idle again
			next_s.sda_oe = 1'b0;
			if (!s.bus_busy && lines_idle) begin
				next_s.st = twm_pkg::M_IDLE;
			end
		end
		default: begin
			next_s.st = twm_pkg::M_IDLE;
		end
		endcase
		// clock low for the first six units, high for the last ones
		if (next_s.st == twm_pkg::M_HOLD) begin
			next_s.scl_oe = 1'b1;
		end else if (next_s.st == twm_pkg::M_IDLE ||
			next_s.st == twm_pkg::M_LOST) begin
			next_s.scl_oe = 1'b0;
		end else begin
			next_s.scl_oe = next_s.ph < twm_pkg::LOW_UNITS;
		end
		next_s.busy = next_s.st != twm_pkg::M_IDLE;
		next_s.pin_sda_oe = ~internal_loop_select &
			(next_s.sda_oe | s_sda_oe);
		next_s.pin_scl_oe = ~internal_loop_select &
			(next_s.scl_oe | s_scl_oe);
	end

	// ==========================================
	// state register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s <= '0;
			s.st <= twm_pkg::M_IDLE;
			s.p_sda <= 1'b1;
			s.p_scl <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================
	// outputs
	assign bus_data_pin_out = s.pin_out;
	assign bus_clock_pin_out = s.pin_out;
	assign bus_data_pin_oe = s.pin_sda_oe;
	assign bus_clock_pin_oe = s.pin_scl_oe;
	assign mst_done = s.done;
	assign mst_error = s.err;
	assign mst_arb_lost = s.lost;
	assign mst_busy = s.busy;
	assign mst_rx_data = s.rdata;
	assign bus_busy = s.bus_busy;
endmodule

// ---- twm_pkg.sv ----
// shared constants and types of the two-wire bus controller
package twm_pkg;
	// ==========================================
	// bus clock shaping, in prescaled units
	localparam logic [3:0] LOW_UNITS   = 4'h6;
	localparam logic [3:0] HIGH_UNITS  = 4'h4;
	localparam logic [3:0] BIT_END     = 4'ha;
	localparam logic [3:0] COND_END    = 4'he;
	localparam int         SYS_CLK_HZ  = 200000000;
	localparam int         RATE_STD    = 100000;
	localparam int         RATE_FAST   = 400000;
	localparam logic [7:0] PRESCALE_STD =
		8'(SYS_CLK_HZ / (20 * RATE_STD) - 1);
	localparam logic [7:0] PRESCALE_FAST =
		8'(SYS_CLK_HZ / (20 * RATE_FAST) - 1);
	// ==========================================
	// reset values and the bit count of a byte
	localparam logic [7:0] BYTE_RST    = 8'h00;
	localparam logic [8:0] PRE_RST     = 9'h000;
	localparam logic [3:0] CNT_RST     = 4'h0;
	localparam logic [3:0] BITS_BYTE   = 4'h8;
	// ==========================================
	// state types
	typedef enum logic [2:0] {
		M_IDLE, M_START, M_DATA, M_ACK, M_HOLD, M_STOP, M_LOST
	} twm_mst_t;
	typedef enum logic [2:0] {
		S_IDLE, S_RX, S_RACK, S_WAIT, S_TX, S_TACK
	} twm_slv_t;
endpackage

// ---- twm_slave.sv ----
// slave function of the two-wire bus controller
`timescale 1ns/1ps
module twm_slave (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       sda_line,
	input  wire logic       scl_line,
	input  wire logic       start_det,
	input  wire logic       stop_det,
	input  wire logic [6:0] own_addr,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_load,
	output logic            sda_oe,
	output logic            scl_oe,
	output logic [7:0]      rx_data,
	output logic            rx_req,
	output logic            tx_req,
	output logic            first_byte
);
	typedef struct packed {
		twm_pkg::twm_slv_t st;
		logic [7:0]        sh;
		logic [3:0]        bitn;
		logic              adr;
		logic              rw;
		logic              first;
		logic              acked;
		logic              sda_oe;
		logic              scl_oe;
		logic              p_scl;
		logic [7:0]        rx_data;
		logic              rx_req;
		logic              tx_req;
		logic              first_byte;
	} twm_sst_t;

	twm_sst_t s;
	twm_sst_t next_s;
	logic     rise;
	logic     fall;

	// ==========================================
	// next state
	always_comb begin
		rise = ~s.p_scl & scl_line;
		fall = s.p_scl & ~scl_line;
		next_s = s;
		next_s.p_scl = scl_line;
		next_s.rx_req = 1'b0;
		next_s.tx_req = 1'b0;
		next_s.first_byte = 1'b0;
		if (start_det) begin
			next_s.st = twm_pkg::S_RX;
			next_s.adr = 1'b1;
			next_s.bitn = twm_pkg::CNT_RST;
			next_s.sda_oe = 1'b0;
			next_s.scl_oe = 1'b0;
		end else if (stop_det) begin
			next_s.st = twm_pkg::S_IDLE;
			next_s.sda_oe = 1'b0;
			next_s.scl_oe = 1'b0;
		end else begin
			case (s.st)
			twm_pkg::S_RX: begin
				if (rise && s.bitn != twm_pkg::BITS_BYTE) begin
					next_s.sh = {s.sh[6:0], sda_line};
					next_s.bitn = s.bitn + 4'h1;
				end else if (fall && s.bitn == twm_pkg::BITS_BYTE) begin
					next_s.st = twm_pkg::S_RACK;
					next_s.sda_oe = 1'b1;
					if (s.adr) begin
						next_s.rw = s.sh[0];
						next_s.first = 1'b1;
						if (s.sh[7:1] != own_addr) begin
							next_s.st = twm_pkg::S_IDLE;
							next_s.sda_oe = 1'b0;
						end
					end else begin
						next_s.rx_data = s.sh;
						next_s.rx_req = 1'b1;
						next_s.first_byte = s.first;
						next_s.first = 1'b0;
					end
				end
			end
			twm_pkg::S_RACK: begin
				if (fall) begin
					next_s.sda_oe = 1'b0;
					next_s.bitn = twm_pkg::CNT_RST;
					next_s.adr = 1'b0;
					next_s.st = twm_pkg::S_RX;
					if (s.adr && s.rw) begin
						next_s.st = twm_pkg::S_WAIT;
						next_s.scl_oe = 1'b1;
						next_s.tx_req = 1'b1;
					end
				end
			end
			twm_pkg::S_WAIT: begin
				// clock held low until the user supplies a byte
				if (tx_load) begin
					next_s.sh = tx_data;
					next_s.sda_oe = ~tx_data[7];
					next_s.scl_oe = 1'b0;
					next_s.bitn = twm_pkg::CNT_RST;
					next_s.st = twm_pkg::S_TX;
				end
			end
			twm_pkg::S_TX: begin
				if (rise) begin
					next_s.bitn = s.bitn + 4'h1;
				end else if (fall) begin
					if (s.bitn == twm_pkg::BITS_BYTE) begin
						next_s.sda_oe = 1'b0;
						next_s.st = twm_pkg::S_TACK;
					end else begin
						next_s.sh = {s.sh[6:0], 1'b0};
						next_s.sda_oe = ~s.sh[6];
					end
				end
			end
			twm_pkg::S_TACK: begin
				if (rise) begin
					next_s.acked = ~sda_line;
				end else if (fall) begin
					next_s.st = twm_pkg::S_IDLE;
					if (s.acked) begin
						next_s.st = twm_pkg::S_WAIT;
						next_s.scl_oe = 1'b1;
						next_s.tx_req = 1'b1;
					end
				end
			end
			default: begin
				next_s.sda_oe = 1'b0;
				next_s.scl_oe = 1'b0;
			end
			endcase
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s <= '0;
			s.st <= twm_pkg::S_IDLE;
			s.p_scl <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign sda_oe = s.sda_oe;
	assign scl_oe = s.scl_oe;
	assign rx_data = s.rx_data;
	assign rx_req = s.rx_req;
	assign tx_req = s.tx_req;
	assign first_byte = s.first_byte;
endmodule

// ---- twm_sva.sv ----
// port checker of the two-wire bus controller
`timescale 1ns/1ps
module twm_sva (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       bus_data_pin_in,
	input wire logic       bus_data_pin_out,
	input wire logic       bus_data_pin_oe,
	input wire logic       bus_clock_pin_in,
	input wire logic       bus_clock_pin_out,
	input wire logic       bus_clock_pin_oe,
	input wire logic [7:0] bus_clock_prescale,
	input wire logic       internal_loop_select,
	input wire logic       mst_cmd_run,
	input wire logic       mst_cmd_start,
	input wire logic       mst_done,
	input wire logic       mst_error,
	input wire logic       mst_busy,
	input wire logic       bus_busy
);
	// ==========================================
	// length of the clock low we drive
	logic [11:0] lo_cnt;
	logic [11:0] low_min;
	// hold and stretch lengthen it, so only a floor
	assign low_min = (12'(bus_clock_prescale) + 12'h001) * 12'h00c;
	always_ff @(posedge clk_sys) begin
		if (rst || !bus_clock_pin_oe)
			lo_cnt <= 12'h000;
		else if (lo_cnt != 12'hfff)
			lo_cnt <= lo_cnt + 12'h001;
	end
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// ==========================================
	// properties
	property p_open_drain;
		!bus_data_pin_out && !bus_clock_pin_out;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("pad driven high");
	property p_loop_release;
		internal_loop_select && $past(internal_loop_select)
			|-> !bus_data_pin_oe && !bus_clock_pin_oe;
	endproperty
	a_loop_release: assert property (p_loop_release)
		else $error("pads used in loop mode");
	property p_data_stable;
		$rose(bus_clock_pin_in) |=> $stable(bus_data_pin_oe) [*3];
	endproperty
	a_data_stable: assert property (p_data_stable)
		else $error("data moved while clock high");
	property p_refuse;
		mst_cmd_run && mst_cmd_start && !mst_busy && bus_busy
			|=> mst_done && mst_error && !bus_data_pin_oe;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("start on busy bus not refused");
	property p_busy_start;
		$fell(bus_data_pin_in) && bus_clock_pin_in
			&& $past(bus_clock_pin_in) |-> ##[1:4] bus_busy;
	endproperty
	a_busy_start: assert property (p_busy_start)
		else $error("start not marked busy");
	property p_free_stop;
		$rose(bus_data_pin_in) && bus_clock_pin_in
			&& $past(bus_clock_pin_in) |-> ##[1:4] !bus_busy;
	endproperty
	a_free_stop: assert property (p_free_stop)
		else $error("stop not marked free");
	property p_low_phase;
		$fell(bus_clock_pin_oe) |-> lo_cnt >= low_min;
	endproperty
	a_low_phase: assert property (p_low_phase)
		else $error("clock low phase short");
	property p_done_pulse;
		mst_done |=> !mst_done;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done longer than a cycle");
endmodule
bind twm_ctrl twm_sva u_sva (
	.clk_sys(clk_sys), .rst(rst), .bus_data_pin_in(bus_data_pin_in),
	.bus_data_pin_out(bus_data_pin_out), .bus_data_pin_oe(bus_data_pin_oe),
	.bus_clock_pin_in(bus_clock_pin_in), .bus_clock_pin_oe(bus_clock_pin_oe),
	.bus_clock_pin_out(bus_clock_pin_out), .mst_busy(mst_busy),
	.bus_clock_prescale(bus_clock_prescale), .mst_cmd_run(mst_cmd_run),
	.internal_loop_select(internal_loop_select), .bus_busy(bus_busy),
	.mst_cmd_start(mst_cmd_start), .mst_done(mst_done), .mst_error(mst_error)
);

// ---- twm_bus_model.sv ----
// far-side slave device on the open-drain bus
`timescale 1ns/1ps
module twm_bus_model (
	input  wire logic       clk_sys,
	input  wire logic       sda_line,
	input  wire logic       scl_line,
	input  wire logic [6:0] dev_addr,
	input  wire logic [7:0] rd_data,
	input  wire logic [7:0] stall,
	output logic            sda_oe,
	output logic            scl_oe,
	output logic [7:0]      addr_seen,
	output logic [7:0]      rx_last,
	output logic            ack_seen
);
	event       never;
	logic [7:0] b;
	// ==========================================
	// bit tasks, lines touched only after clock falls
	task automatic get_byte;
		for (int i = 0; i < 8; i++) begin
			@(posedge scl_line);
			b = {b[6:0], sda_line};
		end
	endtask
	task automatic give_ack;
		@(negedge scl_line);
		@(posedge clk_sys);
		sda_oe <= 1'b1;
		if (stall != 8'h00) begin
			scl_oe <= 1'b1;
			repeat (stall) @(posedge clk_sys);
			scl_oe <= 1'b0;
		end
		@(posedge scl_line);
	endtask
	task automatic send_byte;
		for (int i = 7; i >= 0; i--) begin
			@(negedge scl_line);
			@(posedge clk_sys);
			sda_oe <= !rd_data[i];
			@(posedge scl_line);
		end
		@(negedge scl_line);
		@(posedge clk_sys);
		sda_oe <= 1'b0;
		@(posedge scl_line);
		ack_seen = !sda_line;
	endtask
	// ==========================================
	// one transfer per start, cut short by stop
	initial begin
		{sda_oe, scl_oe, ack_seen} = 3'h0;
		{addr_seen, rx_last} = 16'h0000;
		forever begin
			@(negedge sda_line iff scl_line);
			fork
				begin
					get_byte();
					addr_seen = b;
					if (b[7:1] != dev_addr)
						@(never);
					give_ack();
					if (b[0]) begin
						do send_byte(); while (ack_seen);
					end else begin
						forever begin
							@(negedge scl_line);
							@(posedge clk_sys);
							sda_oe <= 1'b0;
							get_byte();
							rx_last = b;
							give_ack();
						end
					end
					@(never);
				end
				@(posedge sda_line iff scl_line);
			join_any
			disable fork;
			@(posedge clk_sys);
			{sda_oe, scl_oe} <= 2'h0;
		end
	end
endmodule

// ---- twm_tb.sv ----
// self-checking testbench of the two-wire bus controller
`timescale 1ns/1ps
module testbench;
	logic       clk_sys, rst, d_oe, c_oe, m_sda_oe, m_scl_oe, tb_pull;
	logic       loop, run, start, stop, ack, s_load, done, err, busy;
	logic       bbusy, s_rreq, s_treq, s_first, ack_seen;
	logic       halt, fast, lost;
	logic [7:0] mta, tx_data, s_tx, rx, s_rx, addr_seen, rx_last, tpr;
	wire        sda, scl;
	int         errors = 0;
	int         n_compared = 0;
	int         cycles = 0;
	// ==========================================
	// design, far side and pulled-up lines
	twm_ctrl DUT (
		.clk_sys(clk_sys), .rst(rst),
		.bus_data_pin_in(sda), .bus_data_pin_out(), .bus_data_pin_oe(d_oe),
		.bus_clock_pin_in(scl), .bus_clock_pin_out(), .bus_clock_pin_oe(c_oe),
		.bus_clock_prescale(tpr), .speed_fast(fast),
		.internal_loop_select(loop), .master_target_address_reg(mta),
		.mst_tx_data(tx_data), .mst_cmd_run(run), .mst_cmd_start(start),
		.mst_cmd_stop(stop), .mst_cmd_ack(ack), .mst_cmd_halt(halt),
		.mst_done(done), .mst_error(err), .mst_arb_lost(lost),
		.mst_busy(busy),
		.mst_rx_data(rx), .bus_busy(bbusy), .slv_own_addr(7'h2a),
		.slv_tx_data(s_tx), .slv_tx_load(s_load), .slv_rx_data(s_rx),
		.slv_rx_req(s_rreq), .slv_tx_req(s_treq), .slv_first_byte(s_first)
	);
	twm_bus_model u_far (
		.clk_sys(clk_sys), .sda_line(sda), .scl_line(scl),
		.dev_addr(7'h3b), .rd_data(8'h5c), .stall(8'h28),
		.sda_oe(m_sda_oe), .scl_oe(m_scl_oe), .addr_seen(addr_seen),
		.rx_last(rx_last), .ack_seen(ack_seen)
	);
	assign sda = !(d_oe || m_sda_oe || tb_pull);
	assign scl = !(c_oe || m_scl_oe);
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = !clk_sys;
	end
	// a hang anywhere ends here
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			report_and_stop();
		end
	end
	// ==========================================
	// shared tasks
	task automatic check(input string what, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	function automatic logic sel(input int k);
		case (k)
			0: return done;
			1: return !busy && !bbusy;
			2: return s_rreq;
			3: return s_treq;
			default: return bbusy;
		endcase
	endfunction
	// bounded poll, sampled just after each edge
	task automatic wait_for(input int k);
		int n;
		n = 0;
		#1;
		while (sel(k) !== 1'b1 && n < 8000) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check("wait", {7'h00, sel(k)}, 8'h01);
	endtask
	task automatic cmd(input logic [7:0] a, d, input logic s, p, k);
		@(posedge clk_sys);
		{mta, tx_data, start, stop, ack, run} <= {a, d, s, p, k, 1'b1};
		@(posedge clk_sys);
		run <= 1'b0;
	endtask
	// ==========================================
	// scenarios
	task automatic t_write;
		cmd(8'h76, 8'h00, 1'b1, 1'b0, 1'b0);
		wait_for(0);
		check("addr", addr_seen, 8'h76);
		cmd(8'h76, 8'ha5, 1'b0, 1'b0, 1'b0);
		wait_for(0);
		check("byte0", rx_last, 8'ha5);
		cmd(8'h76, 8'h3c, 1'b0, 1'b1, 1'b0);
		wait_for(1);
		check("byte1", rx_last, 8'h3c);
		check("err", {7'h00, err}, 8'h00);
	endtask
	task automatic t_read;
		cmd(8'h77, 8'h00, 1'b1, 1'b0, 1'b0);
		wait_for(0);
		cmd(8'h77, 8'h00, 1'b0, 1'b0, 1'b1);
		wait_for(0);
		check("rd0", rx, 8'h5c);
		check("mack", {7'h00, ack_seen}, 8'h01);
		cmd(8'h77, 8'h00, 1'b0, 1'b1, 1'b0);
		wait_for(1);
		check("rd1", rx, 8'h5c);
		check("mnack", {7'h00, ack_seen}, 8'h00);
	endtask
	task automatic t_nack;
		cmd(8'h24, 8'h00, 1'b1, 1'b0, 1'b0);
		wait_for(0);
		check("nack err", {7'h00, err}, 8'h01);
		wait_for(1);
	endtask
	task automatic t_refuse;
		@(posedge clk_sys);
		tb_pull <= 1'b1;
		wait_for(4);
		cmd(8'h76, 8'h00, 1'b1, 1'b0, 1'b0);
		wait_for(0);
		check("refused", {7'h00, err}, 8'h01);
		check("refused idle", {5'h00, d_oe, c_oe, busy}, 8'h00);
		@(posedge clk_sys);
		tb_pull <= 1'b0;
		wait_for(1);
	endtask
	task automatic t_loop;
		@(posedge clk_sys);
		loop <= 1'b1;
		cmd(8'h54, 8'h00, 1'b1, 1'b0, 1'b0);
		wait_for(0);
		cmd(8'h54, 8'h96, 1'b0, 1'b1, 1'b0);
		wait_for(2);
		check("first", {7'h00, s_first}, 8'h01);
		check("slv rx", s_rx, 8'h96);
		wait_for(1);
		cmd(8'h55, 8'h00, 1'b1, 1'b0, 1'b0);
		fork
			wait_for(0);
			begin
				wait_for(3);
				@(posedge clk_sys);
				{s_tx, s_load} <= {8'h69, 1'b1};
				@(posedge clk_sys);
				s_load <= 1'b0;
			end
		join
		cmd(8'h55, 8'h00, 1'b0, 1'b1, 1'b0);
		wait_for(1);
		check("slv tx", rx, 8'h69);
		check("err", {7'h00, err}, 8'h00);
		@(posedge clk_sys);
		loop <= 1'b0;
	endtask
	// second driver pulls data low while we send a one
	task automatic t_arb;
		cmd(8'h76, 8'h00, 1'b1, 1'b0, 1'b0);
		@(posedge scl);
		@(negedge scl);
		@(posedge clk_sys);
		tb_pull <= 1'b1;
		wait_for(0);
		check("arb", {5'h00, lost, err, d_oe | c_oe}, 8'h06);
		@(posedge clk_sys);
		tb_pull <= 1'b0;
		wait_for(1);
	endtask
	// built-in fast rate; only fast fits the run time
	task automatic t_fast;
		int t0;
		int exp_p;
		exp_p = twm_pkg::SYS_CLK_HZ / twm_pkg::RATE_FAST;
		@(posedge clk_sys);
		{tpr, fast} <= {8'h00, 1'b1};
		cmd(8'h76, 8'h00, 1'b1, 1'b0, 1'b0);
		@(posedge scl);
		t0 = cycles;
		@(posedge scl);
		check("period", 16'(cycles - t0), 16'(exp_p));
		wait_for(0);
		check("fast err", {6'h00, lost, err}, 8'h00);
		@(posedge clk_sys);
		halt <= 1'b1;
		@(posedge clk_sys);
		halt <= 1'b0;
		wait_for(1);
	endtask
	initial begin
		{rst, tb_pull, loop, run, start, stop, ack, s_load} = 8'h80;
		{mta, tx_data, s_tx} = 24'h000000;
		{halt, fast, tpr} = 10'h001;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		check("rst", {d_oe, c_oe, busy, bbusy, done, err, s_rreq, s_treq},
			8'h00);
		check("rst data", rx | s_rx, 8'h00);
		t_write();
		t_read();
		t_nack();
		t_refuse();
		t_loop();
		t_arb();
		t_fast();
		report_and_stop();
	end
endmodule
